// ===== hdl/licp_ctrl.sv
// Overview of operation
// - ringer impedance bit clear gives maximum ringer impedance, set synthesizes it.
// - ring threshold bit selects an 11-22 Vrms window at 0 and 17-33 Vrms at 1.
// - writing 1 to the manual calibration bit starts one calibration cycle.
// - auto-calibration disable bit at 1 suppresses automatic calibration.
// - current limit bit at 1 selects the current-limiting termination mode.
// - off-hook, protection on and loop current all ones: termination off, 800 ohm, low hook current, flag set.
// - off-hook with billing protection on, a rising billing flag gives 800 ohm and freezes the pin.
// - outside a protective response the termination pin follows the receive input.
// - receive overload and billing detection run once the delayed off-hook counter expires.
// - receive overload flag sets on below-ground input and clears only by writing zero.
// - billing tone flag sets on a recognised tone and clears only by writing zero.
// - the delayed off-hook counter is 1024 samples, or 4096 with on-hook speed set.
`timescale 1ns/1ps
`default_nettype none
module licp_ctrl
	import licp_pkg::*;
#(
	parameter int FAST_SAMPLES = OHK_FAST_SAMPLES,
	parameter int SLOW_SAMPLES = OHK_SLOW_SAMPLES
)(
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_sample_tick,
	input wire logic i_off_hook,
	input wire logic [4:0] i_loop_current_sense_field,
	input wire logic i_rx_below_ground,
	input wire logic i_billing_tone_event,
	input wire logic i_cal_done,
	input wire logic [7:0] i_rx_level,
	output logic [7:0] o_dc_termination_pin,
	output logic o_ringer_impedance_synth,
	output logic o_ring_threshold_select,
	output logic o_manual_cal_start,
	output logic o_auto_cal_enable,
	output logic o_current_limit_select,
	output logic o_dc_term_off_800,
	output logic o_hook_current_reduced,
	output logic o_irq
);
	typedef struct packed {
		logic [7:0] ctrl_one;
		logic [7:0] ctrl_two;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_en;
		logic overload_det;
		logic billing_hold;
		logic btd_prev;
		logic [OHK_CNT_W-1:0] ohk_cnt;
		logic ohk_done;
		logic cal_busy;
		logic [7:0] rdata;
		logic [7:0] dc_termination_pin;
		logic manual_cal_start_pulse;
		logic irq;
	} licp_state_t;

	licp_state_t s_q;
	licp_state_t s_d;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
		hit = (a == {idx, 2'b00});
	endfunction

	logic ohk_expired;
	logic ovl_trip;
	logic btd_rise;
	logic [OHK_CNT_W-1:0] ohk_limit;

	always_comb
	begin
		ohk_limit = s_q.ctrl_one[C1_OHS] ? OHK_CNT_W'(SLOW_SAMPLES) : OHK_CNT_W'(FAST_SAMPLES);
		ohk_expired = s_q.ohk_done;
		ovl_trip = i_off_hook && s_q.ctrl_two[C2_OPE]
			&& (i_loop_current_sense_field == LOOP_CUR_ALL_ONES);
		btd_rise = s_q.ctrl_two[C2_BTD] && !s_q.btd_prev;
		s_d = s_q;
		s_d.manual_cal_start_pulse = 1'b0;
		s_d.btd_prev = s_q.ctrl_two[C2_BTD];
		// delayed off-hook counter
		if (!i_off_hook)
		begin
			s_d.ohk_cnt = '0;
			s_d.ohk_done = 1'b0;
		end
		else if (!s_q.ohk_done && i_sample_tick)
		begin
			s_d.ohk_cnt = s_q.ohk_cnt + OHK_CNT_W'(1);
			if (s_q.ohk_cnt + OHK_CNT_W'(1) >= ohk_limit)
			begin
				s_d.ohk_cnt = ohk_limit;
				s_d.ohk_done = 1'b1;
			end
		end
		// overload protection state, released by writing the enable to 0
		if (!s_q.ctrl_two[C2_OPE])
			s_d.overload_det = 1'b0;
		else if (ovl_trip)
			s_d.overload_det = 1'b1;
		// billing protection hold
		if (!i_off_hook || !s_q.ctrl_two[C2_BTE])
			s_d.billing_hold = 1'b0;
		else if (btd_rise)
			s_d.billing_hold = 1'b1;
		if (i_cal_done)
			s_d.cal_busy = 1'b0;
		// register writes
		if (i_wr)
		begin
			if (hit(i_addr, REG_CTRL_ONE_IDX))
				s_d.ctrl_one = i_wdata;
			if (hit(i_addr, REG_CTRL_TWO_IDX))
			begin
				s_d.ctrl_two[C2_RSVD] = 1'b0;
				s_d.ctrl_two[C2_AUTO_CAL_DISABLE:C2_BTE] = i_wdata[C2_AUTO_CAL_DISABLE:C2_BTE];
				s_d.ctrl_two[C2_MANUAL_CAL_START] = i_wdata[C2_MANUAL_CAL_START];
				// flags clear only by writing zero
				if (!i_wdata[C2_ROV])
					s_d.ctrl_two[C2_ROV] = 1'b0;
				if (!i_wdata[C2_BTD])
					s_d.ctrl_two[C2_BTD] = 1'b0;
				if (i_wdata[C2_MANUAL_CAL_START])
				begin
					s_d.manual_cal_start_pulse = 1'b1;
					s_d.cal_busy = 1'b1;
				end
			end
			if (hit(i_addr, REG_IRQ_ENABLE_IDX))
				s_d.irq_en = i_wdata[IRQ_W-1:0];
			if (hit(i_addr, REG_IRQ_CLEAR_IDX))
				s_d.irq_stat = s_q.irq_stat & ~i_wdata[IRQ_W-1:0];
		end
		// detection sets win over clears
		if (ohk_expired && i_rx_below_ground)
		begin
			s_d.ctrl_two[C2_ROV] = 1'b1;
			s_d.irq_stat[IRQ_ROV] = 1'b1;
		end
		if (ohk_expired && i_billing_tone_event)
		begin
			s_d.ctrl_two[C2_BTD] = 1'b1;
			s_d.irq_stat[IRQ_BTD] = 1'b1;
		end
		if (ovl_trip && !s_q.overload_det)
			s_d.irq_stat[IRQ_OPD] = 1'b1;
		// read data
		s_d.rdata = 8'h00;
		if (i_rd)
		begin
			if (hit(i_addr, REG_CTRL_ONE_IDX))
				s_d.rdata = s_q.ctrl_one;
			else if (hit(i_addr, REG_CTRL_TWO_IDX))
				s_d.rdata = s_q.ctrl_two;
			else if (hit(i_addr, REG_IRQ_STATUS_IDX))
				s_d.rdata = {5'h00, s_q.irq_stat};
			else if (hit(i_addr, REG_IRQ_ENABLE_IDX))
				s_d.rdata = {5'h00, s_q.irq_en};
			else if (hit(i_addr, REG_LINE_STATUS_IDX))
				s_d.rdata = {4'h0, s_q.cal_busy, s_q.billing_hold, s_q.ohk_done,
					s_q.overload_det};
		end
		// termination pin tracks receive input unless protecting
		if (!(s_d.overload_det || s_d.billing_hold))
			s_d.dc_termination_pin = i_rx_level;
		s_d.irq = |(s_d.irq_stat & s_d.irq_en);
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			s_q <= '0;
			s_q.ctrl_one <= CTRL_ONE_RST;
			s_q.ctrl_two <= CTRL_TWO_RST;
		end
		else
			s_q <= s_d;
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_ringer_impedance_synth <= 1'b0;
			o_ring_threshold_select <= 1'b0;
			o_auto_cal_enable <= 1'b1;
			o_current_limit_select <= 1'b0;
			o_dc_term_off_800 <= 1'b0;
			o_hook_current_reduced <= 1'b0;
		end
		else
		begin
			o_ringer_impedance_synth <= s_d.ctrl_one[C1_RZ];
			o_ring_threshold_select <= s_d.ctrl_one[C1_RT];
			o_auto_cal_enable <= !s_d.ctrl_two[C2_AUTO_CAL_DISABLE];
			o_current_limit_select <= s_d.ctrl_two[C2_LIM];
			o_dc_term_off_800 <= s_d.overload_det || s_d.billing_hold;
			o_hook_current_reduced <= s_d.overload_det;
		end
	end

	assign o_rdata = s_q.rdata;
	assign o_dc_termination_pin = s_q.dc_termination_pin;
	assign o_manual_cal_start = s_q.manual_cal_start_pulse;
	assign o_irq = s_q.irq;

	logic wr_one;
	logic wr_two;
	logic wr_manual_cal_start;

	assign wr_one = i_wr && hit(i_addr, REG_CTRL_ONE_IDX);
	assign wr_two = i_wr && hit(i_addr, REG_CTRL_TWO_IDX);
	assign wr_manual_cal_start = wr_two && i_wdata[C2_MANUAL_CAL_START];

	sequence s_wr_manual_cal_start;
		wr_manual_cal_start;
	endsequence

	sequence s_ovl_start;
		ovl_trip && !s_q.overload_det;
	endsequence

	sequence s_btd_arm;
		i_off_hook && s_q.ctrl_two[C2_BTE] && btd_rise;
	endsequence

	sequence s_btd_kept;
		s_q.billing_hold && i_off_hook && s_q.ctrl_two[C2_BTE];
	endsequence

	sequence s_rov_set;
		ohk_expired && i_rx_below_ground;
	endsequence

	sequence s_btd_set;
		ohk_expired && i_billing_tone_event;
	endsequence

	a_rz_follow: assert property (@(posedge i_mclk) disable iff (i_rst)
		wr_one |=> o_ringer_impedance_synth == $past(i_wdata[C1_RZ]))
		else $error("ringer impedance select wrong");

	a_rt_follow: assert property (@(posedge i_mclk) disable iff (i_rst)
		wr_one |=> o_ring_threshold_select == $past(i_wdata[C1_RT]))
		else $error("ring threshold select wrong");

	a_manual_cal_start_pulse_one: assert property (@(posedge i_mclk) disable iff (i_rst)
		s_wr_manual_cal_start |=> o_manual_cal_start)
		else $error("manual calibration pulse missing");

	a_manual_cal_start_pulse_end: assert property (@(posedge i_mclk) disable iff (i_rst)
		!wr_manual_cal_start |=> !o_manual_cal_start)
		else $error("manual calibration pulse without write");

	a_auto_cal_disable_follow: assert property (@(posedge i_mclk) disable iff (i_rst)
		wr_two |=> o_auto_cal_enable == !$past(i_wdata[C2_AUTO_CAL_DISABLE]))
		else $error("auto calibration enable wrong");

	a_lim_follow: assert property (@(posedge i_mclk) disable iff (i_rst)
		wr_two |=> o_current_limit_select == $past(i_wdata[C2_LIM]))
		else $error("current limit select wrong");

	a_ovl_response: assert property (@(posedge i_mclk) disable iff (i_rst)
		ovl_trip |=> o_dc_term_off_800 && o_hook_current_reduced)
		else $error("overload response missing");

	a_opd_flag: assert property (@(posedge i_mclk) disable iff (i_rst)
		s_ovl_start |=> s_q.irq_stat[IRQ_OPD] && s_q.overload_det)
		else $error("overload detected flag missing");

	a_hook_level: assert property (@(posedge i_mclk) disable iff (i_rst)
		o_hook_current_reduced == s_q.overload_det
		&& o_dc_term_off_800 == (s_q.overload_det || s_q.billing_hold))
		else $error("protection outputs disagree with state");

	a_ope_release: assert property (@(posedge i_mclk) disable iff (i_rst)
		!s_q.ctrl_two[C2_OPE] |=> !s_q.overload_det)
		else $error("overload state not released");

	a_btd_protect: assert property (@(posedge i_mclk) disable iff (i_rst)
		s_btd_arm |=> o_dc_term_off_800)
		else $error("billing protection missing");

	a_btd_freeze: assert property (@(posedge i_mclk) disable iff (i_rst)
		s_btd_arm |=> $stable(o_dc_termination_pin))
		else $error("termination pin moved on billing tone");

	a_hold_freeze: assert property (@(posedge i_mclk) disable iff (i_rst)
		s_btd_kept |=> $stable(o_dc_termination_pin))
		else $error("termination pin moved during billing hold");

	a_hold_release: assert property (@(posedge i_mclk) disable iff (i_rst)
		!i_off_hook || !s_q.ctrl_two[C2_BTE] |=> !s_q.billing_hold)
		else $error("billing hold not released");

	a_dct_track: assert property (@(posedge i_mclk) disable iff (i_rst)
		!s_d.overload_det && !s_d.billing_hold |=> o_dc_termination_pin == $past(i_rx_level))
		else $error("termination pin not tracking");

	a_rov_gate: assert property (@(posedge i_mclk) disable iff (i_rst)
		!ohk_expired && !s_q.ctrl_two[C2_ROV] && !wr_two
		|=> !s_q.ctrl_two[C2_ROV])
		else $error("overload flag set before counter expiry");

	a_btd_gate: assert property (@(posedge i_mclk) disable iff (i_rst)
		!ohk_expired && !s_q.ctrl_two[C2_BTD] && !wr_two
		|=> !s_q.ctrl_two[C2_BTD])
		else $error("billing flag set before counter expiry");

	a_rov_sticky: assert property (@(posedge i_mclk) disable iff (i_rst)
		s_rov_set |=> s_q.ctrl_two[C2_ROV])
		else $error("receive overload flag lost");

	a_rov_hold: assert property (@(posedge i_mclk) disable iff (i_rst)
		s_q.ctrl_two[C2_ROV] && !wr_two |=> s_q.ctrl_two[C2_ROV])
		else $error("overload flag dropped without write");

	a_rov_clear: assert property (@(posedge i_mclk) disable iff (i_rst)
		wr_two && !i_wdata[C2_ROV] && !(ohk_expired && i_rx_below_ground)
		|=> !s_q.ctrl_two[C2_ROV])
		else $error("overload flag not cleared by zero");

	a_btd_set: assert property (@(posedge i_mclk) disable iff (i_rst)
		s_btd_set |=> s_q.ctrl_two[C2_BTD])
		else $error("billing flag not set");

	a_btd_sticky: assert property (@(posedge i_mclk) disable iff (i_rst)
		s_q.ctrl_two[C2_BTD] && !wr_two
		|=> s_q.ctrl_two[C2_BTD])
		else $error("billing flag dropped without write");

	a_btd_clear: assert property (@(posedge i_mclk) disable iff (i_rst)
		wr_two && !i_wdata[C2_BTD] && !(ohk_expired && i_billing_tone_event)
		|=> !s_q.ctrl_two[C2_BTD])
		else $error("billing flag not cleared by zero");

	a_ohk_length: assert property (@(posedge i_mclk) disable iff (i_rst)
		$rose(s_q.ohk_done) |-> s_q.ohk_cnt == ohk_limit)
		else $error("off-hook counter length wrong");

	a_ohk_restart: assert property (@(posedge i_mclk) disable iff (i_rst)
		!i_off_hook |=> s_q.ohk_cnt == OHK_CNT_W'(0) && !s_q.ohk_done)
		else $error("off-hook counter not restarted");

	a_rsvd_zero: assert property (@(posedge i_mclk) disable iff (i_rst)
		!s_q.ctrl_two[C2_RSVD])
		else $error("reserved bit set");

	a_irq_level: assert property (@(posedge i_mclk) disable iff (i_rst)
		o_irq == |(s_q.irq_stat & s_q.irq_en))
		else $error("interrupt level wrong");

	a_rdata_idle: assert property (@(posedge i_mclk) disable iff (i_rst)
		!i_rd |=> o_rdata == 8'h00)
		else $error("read data outside read cycle");
endmodule // licp_ctrl
`default_nettype wire

// ===== hdl/licp_pkg.sv
package licp_pkg;
	// register indices (byte address = index * 4)
	localparam logic [7:0] REG_CTRL_ONE_IDX = 8'h10;
	localparam logic [7:0] REG_CTRL_TWO_IDX = 8'h11;
	localparam logic [7:0] REG_IRQ_STATUS_IDX = 8'h12;
	localparam logic [7:0] REG_IRQ_ENABLE_IDX = 8'h13;
	localparam logic [7:0] REG_IRQ_CLEAR_IDX = 8'h14;
	localparam logic [7:0] REG_LINE_STATUS_IDX = 8'h15;
	localparam int ADDR_W = 10;
	// control one fields
	localparam int C1_RT = 0;
	localparam int C1_RZ = 1;
	localparam int C1_OHS = 6;
	// control two fields
	localparam int C2_BTD = 0;
	localparam int C2_ROV = 1;
	localparam int C2_BTE = 2;
	localparam int C2_OPE = 3;
	localparam int C2_LIM = 4;
	localparam int C2_AUTO_CAL_DISABLE = 5;
	localparam int C2_MANUAL_CAL_START = 6;
	localparam int C2_RSVD = 7;
	// interrupt status fields
	localparam int IRQ_ROV = 0;
	localparam int IRQ_BTD = 1;
	localparam int IRQ_OPD = 2;
	localparam int IRQ_W = 3;
	localparam logic [7:0] CTRL_ONE_RST = 8'h00;
	localparam logic [7:0] CTRL_TWO_RST = 8'h00;
	localparam logic [4:0] LOOP_CUR_ALL_ONES = 5'h1F;
	localparam int OHK_FAST_SAMPLES = 1024;
	localparam int OHK_SLOW_SAMPLES = 4096;
	localparam int OHK_CNT_W = 13;
endpackage

// ===== verif/licp_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module licp_line_model (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_cal_start,
	output logic o_tick,
	output logic o_cal_done,
	output logic [7:0] o_rx
);
	logic [2:0] div_q;
	// tick every 8 clocks, new receive sample every clock, calibration ends one clock later
	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			div_q <= 3'h0;
			o_rx <= 8'h5A;
			o_cal_done <= 1'b0;
		end
		else
		begin
			div_q <= div_q + 3'h1;
			o_rx <= o_rx + 8'h01;
			o_cal_done <= i_cal_start;
		end
	end
	assign o_tick = (div_q == 3'h7);
endmodule // licp_line_model
`default_nettype wire

// ===== verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import licp_pkg::*;
	localparam int FS = 4;
	localparam int SS = 16;
	logic i_mclk = 1'b0;
	logic i_rst = 1'b1;
	logic [ADDR_W-1:0] i_addr = '0;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0, i_rd = 1'b0, i_off_hook = 1'b0;
	logic i_rx_below_ground = 1'b0, i_billing_tone_event = 1'b0;
	logic [4:0] i_loop_current_sense_field = 5'h1E;
	logic i_sample_tick, i_cal_done, o_manual_cal_start, o_auto_cal_enable, o_irq;
	logic o_ringer_impedance_synth, o_ring_threshold_select, o_current_limit_select;
	logic o_dc_term_off_800, o_hook_current_reduced;
	logic [7:0] i_rx_level, o_dc_termination_pin, o_rdata, rv, fl;
	int err_count = 0, check_count = 0, ticks = 0;
	assign fl = {o_irq, o_hook_current_reduced, o_dc_term_off_800, o_current_limit_select,
		o_auto_cal_enable, o_manual_cal_start, o_ringer_impedance_synth, o_ring_threshold_select};
	licp_ctrl #(.FAST_SAMPLES(FS), .SLOW_SAMPLES(SS)) dut (.*);
	licp_line_model line (.i_mclk(i_mclk), .i_rst(i_rst), .i_cal_start(o_manual_cal_start),
		.o_tick(i_sample_tick), .o_cal_done(i_cal_done), .o_rx(i_rx_level));
	always #5 i_mclk = ~i_mclk;
	always @(posedge i_mclk) ticks <= !i_off_hook ? 0 : ticks + int'(i_sample_tick);
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e)
		begin
			err_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic acc(input logic [7:0] idx, input logic [7:0] d, input logic w);
		@(posedge i_mclk);
		i_addr <= {idx, 2'b00};
		i_wdata <= d;
		i_wr <= w;
		i_rd <= !w;
		@(posedge i_mclk);
		i_wr <= 1'b0;
		i_rd <= 1'b0;
		#1;
		rv = o_rdata;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		acc(idx, d, 1'b1);
	endtask
	task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
		acc(idx, 8'h00, 1'b0);
		chk(rv, e);
	endtask
	task automatic wait_ohk(input int n);
		rv = 8'h00;
		for (int i = 0; i < 300 && rv[1] !== 1'b1; i++)
			acc(REG_LINE_STATUS_IDX, 8'h00, 1'b0);
		if (rv[1] !== 1'b1)
		begin
			err_count++;
			results();
		end
		else
			chk(8'(ticks), 8'(n));
	endtask
	task automatic t_ctrl();
		rchk(REG_CTRL_ONE_IDX, CTRL_ONE_RST);
		rchk(8'h20, 8'h00);
		chk(fl, 8'h08);
		wr(REG_CTRL_ONE_IDX, 8'h03);
		chk(fl, 8'h0B);
		wr(REG_CTRL_ONE_IDX, 8'h00);
		chk(fl, 8'h08);
		wr(REG_CTRL_TWO_IDX, 8'h70);
		chk(fl, 8'h14);
		rchk(REG_CTRL_TWO_IDX, 8'h70);
		chk(fl, 8'h10);
		wr(REG_CTRL_TWO_IDX, 8'h00);
		chk(fl, 8'h08);
		$display("test control done");
	endtask
	task automatic t_flags();
		@(posedge i_mclk);
		i_off_hook <= 1'b1;
		i_rx_below_ground <= 1'b1;
		rchk(REG_CTRL_TWO_IDX, 8'h00);
		wait_ohk(FS);
		@(posedge i_mclk);
		i_rx_below_ground <= 1'b0;
		i_billing_tone_event <= 1'b1;
		rchk(REG_CTRL_TWO_IDX, 8'h03);
		@(posedge i_mclk);
		i_billing_tone_event <= 1'b0;
		wr(REG_CTRL_TWO_IDX, 8'h03);
		rchk(REG_CTRL_TWO_IDX, 8'h03);
		chk(fl, 8'h08);
		wr(REG_CTRL_TWO_IDX, 8'h01);
		rchk(REG_CTRL_TWO_IDX, 8'h01);
		wr(REG_CTRL_TWO_IDX, 8'h00);
		rchk(REG_CTRL_TWO_IDX, 8'h00);
		wr(REG_IRQ_ENABLE_IDX, 8'h01);
		rchk(REG_IRQ_STATUS_IDX, 8'h03);
		chk(fl, 8'h88);
		wr(REG_IRQ_CLEAR_IDX, 8'h01);
		rchk(REG_IRQ_STATUS_IDX, 8'h02);
		chk(fl, 8'h08);
		$display("test flags done");
	endtask
	task automatic t_prot();
		chk(o_dc_termination_pin, i_rx_level - 8'h01);
		wr(REG_CTRL_TWO_IDX, 8'h08);
		rchk(REG_CTRL_TWO_IDX, 8'h08);
		chk(fl, 8'h08);
		@(posedge i_mclk);
		i_loop_current_sense_field <= LOOP_CUR_ALL_ONES;
		rchk(REG_LINE_STATUS_IDX, 8'h03);
		chk(fl, 8'h68);
		@(posedge i_mclk);
		i_loop_current_sense_field <= 5'h1E;
		wr(REG_CTRL_TWO_IDX, 8'h04);
		rchk(REG_CTRL_TWO_IDX, 8'h04);
		chk(fl, 8'h08);
		@(posedge i_mclk);
		i_billing_tone_event <= 1'b1;
		rchk(REG_CTRL_TWO_IDX, 8'h05);
		@(posedge i_mclk);
		i_billing_tone_event <= 1'b0;
		@(posedge i_mclk);
		#1;
		rv = o_dc_termination_pin;
		repeat (3) @(posedge i_mclk);
		#1;
		chk(o_dc_termination_pin, rv);
		chk(fl, 8'h28);
		wr(REG_CTRL_TWO_IDX, 8'h00);
		repeat (2) @(posedge i_mclk);
		#1;
		chk(o_dc_termination_pin, i_rx_level - 8'h01);
		$display("test protection done");
	endtask
	task automatic t_slow();
		wr(REG_CTRL_ONE_IDX, 8'h40);
		@(posedge i_mclk);
		i_off_hook <= 1'b0;
		repeat (3) @(posedge i_mclk);
		i_off_hook <= 1'b1;
		wait_ohk(SS);
		$display("test slow counter done");
	endtask
	initial
	begin
		repeat (2) @(posedge i_mclk);
		i_rst <= 1'b0;
		t_ctrl();
		t_flags();
		t_prot();
		t_slow();
		results();
	end
endmodule // testbench
`default_nettype wire
